// *** include/mdt_pkg.sv ***
// package: constants and types of the descriptor element decoder
package mdt_pkg;
  localparam logic [7:0] TYP_PROFILE  = 8'h04;
  localparam logic [7:0] TYP_IPINIT   = 8'h05;
  localparam logic [7:0] TYP_SECURE   = 8'h06;
  localparam logic [7:0] SUB_SPACING  = 8'h01;
  localparam logic [7:0] SUB_VERBOSE  = 8'h02;
  localparam logic [7:0] SUB_FRAG     = 8'h03;
  localparam logic [7:0] SUB_PROV     = 8'h01;
  localparam logic [7:0] SUB_PRESID   = 8'h02;
  localparam logic [7:0] LEN_ONE      = 8'h01;
  localparam logic [7:0] LEN_PRESID   = 8'h03;
  localparam logic [7:0] MAX_BINARY   = 8'h01;
  localparam logic [7:0] MAX_PROV     = 8'h03;
  localparam logic [7:0] FRAG_PERMIT  = 8'h01;
  localparam logic [3:0] SID_RSVD_VAL = 4'h0;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_SID      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam int         CTRL_EN_BIT  = 0;
  localparam logic       CTRL_EN_RST  = 1'b1;
  localparam int         ST_SPACING   = 0;
  localparam int         ST_VERBOSE   = 1;
  localparam int         ST_FRAG      = 2;
  localparam int         ST_PROV      = 3;
  localparam int         ST_SECURE    = 5;
  localparam int         ST_PROF_SEEN = 8;
  localparam int         ST_IP_SEEN   = 9;
  localparam int         ST_SEC_SEEN  = 10;
  localparam int         ST_SID_SEEN  = 11;
  localparam int         IRQ_PROF     = 0;
  localparam int         IRQ_IP       = 1;
  localparam int         IRQ_SEC      = 2;
  localparam int         IRQ_ERR      = 3;
  localparam int         IRQ_W        = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [1:0] PROV_RST     = 2'h0;
  localparam logic [19:0] SID_RST     = 20'h00000;
  typedef enum logic [2:0] {
    PS_TTYPE = 3'b000,
    PS_TLEN  = 3'b001,
    PS_TSKIP = 3'b010,
    PS_STYPE = 3'b011,
    PS_SLEN  = 3'b100,
    PS_SVAL  = 3'b101,
    PS_EVAL  = 3'b110
  } mdt_state_t;
endpackage

// *** include/mdt_cfg_if.sv ***
// interface: decoded settings and events between parser and register file
`timescale 1ns/1ps
interface mdt_cfg_if;
  logic        dec_en;
  logic        spacing_8m;
  logic        verbose;
  logic        frag;
  logic [1:0]  prov;
  logic [19:0] sid;
  logic        sec;
  logic [3:0]  seen;
  logic [3:0]  ev;
  modport core (input dec_en, output spacing_8m, verbose, frag, prov, sid, sec, seen, ev);
  modport regs (output dec_en, input spacing_8m, verbose, frag, prov, sid, sec, seen, ev);
endinterface

// *** hw/mdt_wb_regs.sv ***
// wishbone register file with sticky interrupt status
`timescale 1ns/1ps
module mdt_wb_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_adr,
  input  wire logic [31:0]       i_dat,
  input  wire logic [3:0]        i_sel,
  input  wire logic              i_we,
  input  wire logic              i_cyc,
  input  wire logic              i_stb,
  output logic [31:0]            o_dat,
  output logic                   o_ack,
  output logic                   o_irq,
  mdt_cfg_if.regs                cfg
);
  logic [31:0]      rd;
  logic             req;
  logic             wr;
  logic [7:0]       adr;
  logic [3:0]       istat_q;
  logic [3:0]       imask_q;
  logic [3:0]       istat_d;
  logic             en_q;

  if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
    $error("ADDR_W must be 5 to 8");
  end

  assign req = i_cyc && i_stb && !o_ack;
  assign wr  = req && i_we && i_sel[0];
  assign adr = 8'(i_adr);
  assign cfg.dec_en = en_q;

  always_comb begin
    rd = 32'h0000_0000;
    if (adr == mdt_pkg::OFS_CTRL) begin
      rd[mdt_pkg::CTRL_EN_BIT] = en_q;
    end else if (adr == mdt_pkg::OFS_STATUS) begin
      rd[mdt_pkg::ST_SPACING] = cfg.spacing_8m;
      rd[mdt_pkg::ST_VERBOSE] = cfg.verbose;
      rd[mdt_pkg::ST_FRAG] = cfg.frag;
      rd[mdt_pkg::ST_PROV +: 2] = cfg.prov;
      rd[mdt_pkg::ST_SECURE] = cfg.sec;
      rd[mdt_pkg::ST_PROF_SEEN +: 4] = cfg.seen;
    end else if (adr == mdt_pkg::OFS_SID) begin
      rd[19:0] = cfg.sid;
    end else if (adr == mdt_pkg::OFS_IRQ_STAT) begin
      rd[3:0] = istat_q;
    end else if (adr == mdt_pkg::OFS_IRQ_MASK) begin
      rd[3:0] = imask_q;
    end
  end

  // event set wins over write-one-to-clear
  always_comb begin
    istat_d = istat_q;
    if (wr && adr == mdt_pkg::OFS_IRQ_STAT) begin
      istat_d = istat_q & ~i_dat[3:0];
    end
    istat_d = istat_d | cfg.ev;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      o_dat <= 32'h0000_0000;
    end else begin
      o_ack <= req;
      o_dat <= (req && !i_we) ? rd : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q    <= mdt_pkg::CTRL_EN_RST;
      imask_q <= mdt_pkg::IRQ_MASK_RST;
    end else if (wr && adr == mdt_pkg::OFS_CTRL) begin
      en_q <= i_dat[mdt_pkg::CTRL_EN_BIT];
    end else if (wr && adr == mdt_pkg::OFS_IRQ_MASK) begin
      imask_q <= i_dat[3:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      istat_q <= 4'h0;
      o_irq   <= 1'b0;
    end else begin
      istat_q <= istat_d;
      o_irq   <= |(istat_d & imask_q);
    end
  end
endmodule

// *** hw/mdt_decoder.sv ***
// descriptor element decoder top: byte parser, settings, register file
// Operation
// RL1 - the headend sends the profile-reporting element 4 only on primary-capable channels.
// RL2 - a compound length counts all nested sub-elements, each with one type and one length byte.
// RL3 - sub-element 4.1 value 0 selects 6 MHz spacing, 1 selects 8 MHz, others are reserved.
// RL4 - sub-element 4.2 value 0 forbids and 1 requires verbose reporting, others are reserved.
// RL5 - sub-element 4.3 value 1 permits fragmented profiles and its absence forbids them.
// RL6 - the headend sends the IP-initialization element 5 only on primary-capable channels.
// RL7 - sub-element 5.1 must be present and maps 0 to 3 onto the four provisioning modes.
// RL8 - sub-element 5.2 is three bytes whose low 20 bits are the pre-registration identifier.
// RL9 - the headend sends 5.2 only while multicast identifier forwarding is in use.
// RL10 - the headend sends the security element 6 only on primary-capable channels.
// RL11 - element 6 is one byte where 0 disables and 1 enables early authentication.
// RL12 - unknown sub-elements are skipped by length and bad values or lengths raise an error.
`timescale 1ns/1ps
module mdt_decoder #(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_tlv_start,
  input  wire logic              i_tlv_valid,
  input  wire logic [7:0]        i_tlv_byte,
  input  wire logic [ADDR_W-1:0] i_wb_adr,
  input  wire logic [31:0]       i_wb_dat,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic              i_wb_we,
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  output logic [31:0]            o_wb_dat,
  output logic                   o_wb_ack,
  output logic                   o_irq,
  output logic                   o_spacing_8m,
  output logic                   o_verbose,
  output logic                   o_frag_permit,
  output logic [1:0]             o_prov_mode,
  output logic [19:0]            o_prereg_sid,
  output logic                   o_early_auth_en,
  output logic                   o_parse_err
);
  mdt_cfg_if cfg ();

  mdt_pkg::mdt_state_t state_q;
  mdt_pkg::mdt_state_t state_d;
  mdt_pkg::mdt_state_t cur;
  logic [7:0]  top_type_q;
  logic [7:0]  top_type_d;
  logic [7:0]  sub_type_q;
  logic [7:0]  sub_type_d;
  logic [7:0]  top_rem_q;
  logic [7:0]  top_rem_d;
  logic [7:0]  sub_rem_q;
  logic [7:0]  sub_rem_d;
  logic [23:0] acc_q;
  logic [23:0] acc_d;
  logic        sub_bad_q;
  logic        sub_bad_d;
  logic        seen_frag_q;
  logic        seen_frag_d;
  logic        seen_prov_q;
  logic        seen_prov_d;
  logic [23:0] val;
  logic [7:0]  rem_after;
  logic [7:0]  exp_len;
  logic        commit;
  logic        end_ok;
  logic        sec_take;
  logic        err;
  logic        upd_spacing;
  logic        upd_verbose;
  logic        upd_frag;
  logic        upd_prov;
  logic        upd_sid;
  logic        upd_sec;
  logic        clr_frag;
  logic        is_prof;
  logic        is_ip;
  logic [3:0]  ev_q;
  logic [3:0]  seen_q;

  assign val       = {acc_q[15:0], i_tlv_byte};
  assign rem_after = top_rem_q - 8'h01;
  assign is_prof   = top_type_q == mdt_pkg::TYP_PROFILE;
  assign is_ip     = top_type_q == mdt_pkg::TYP_IPINIT;

  // expected value length of known sub-elements
  always_comb begin
    exp_len = 8'h00;
    if (is_prof && (sub_type_q == mdt_pkg::SUB_SPACING || sub_type_q == mdt_pkg::SUB_VERBOSE
        || sub_type_q == mdt_pkg::SUB_FRAG)) begin
      exp_len = mdt_pkg::LEN_ONE;
    end else if (is_ip && sub_type_q == mdt_pkg::SUB_PROV) begin
      exp_len = mdt_pkg::LEN_ONE;
    end else if (is_ip && sub_type_q == mdt_pkg::SUB_PRESID) begin
      exp_len = mdt_pkg::LEN_PRESID;
    end
  end

  // byte parser
  always_comb begin
    cur         = i_tlv_start ? mdt_pkg::PS_TTYPE : state_q;
    state_d     = state_q;
    top_type_d  = top_type_q;
    sub_type_d  = sub_type_q;
    top_rem_d   = top_rem_q;
    sub_rem_d   = sub_rem_q;
    acc_d       = acc_q;
    sub_bad_d   = sub_bad_q;
    commit      = 1'b0;
    end_ok      = 1'b0;
    sec_take    = 1'b0;
    err         = 1'b0;
    if (!cfg.dec_en) begin
      state_d = mdt_pkg::PS_TTYPE;
    end else if (i_tlv_valid) begin
      case (cur)
        mdt_pkg::PS_TTYPE: begin
          top_type_d = i_tlv_byte;
          state_d    = mdt_pkg::PS_TLEN;
        end
        mdt_pkg::PS_TLEN: begin
          top_rem_d = i_tlv_byte;
          if (top_type_q == mdt_pkg::TYP_PROFILE || top_type_q == mdt_pkg::TYP_IPINIT) begin
            if (i_tlv_byte == 8'h00) begin
              end_ok  = 1'b1; // RL2
              state_d = mdt_pkg::PS_TTYPE;
            end else begin
              state_d = mdt_pkg::PS_STYPE;
            end
          end else if (top_type_q == mdt_pkg::TYP_SECURE) begin
            if (i_tlv_byte == mdt_pkg::LEN_ONE) begin
              state_d = mdt_pkg::PS_EVAL; // RL11
            end else begin
              err     = 1'b1; // RL12
              state_d = (i_tlv_byte == 8'h00) ? mdt_pkg::PS_TTYPE : mdt_pkg::PS_TSKIP;
            end
          end else begin
            state_d = (i_tlv_byte == 8'h00) ? mdt_pkg::PS_TTYPE : mdt_pkg::PS_TSKIP;
          end
        end
        mdt_pkg::PS_TSKIP: begin
          top_rem_d = rem_after;
          if (top_rem_q == 8'h01) begin
            state_d = mdt_pkg::PS_TTYPE;
          end
        end
        mdt_pkg::PS_EVAL: begin
          sec_take = 1'b1;
          state_d  = mdt_pkg::PS_TTYPE;
        end
        mdt_pkg::PS_STYPE: begin
          sub_type_d = i_tlv_byte;
          top_rem_d  = rem_after;
          if (top_rem_q == 8'h01) begin
            err     = 1'b1; // RL2
            state_d = mdt_pkg::PS_TTYPE;
          end else begin
            state_d = mdt_pkg::PS_SLEN;
          end
        end
        mdt_pkg::PS_SLEN: begin
          top_rem_d = rem_after;
          sub_rem_d = i_tlv_byte;
          acc_d     = 24'h000000;
          if (i_tlv_byte > rem_after) begin
            err     = 1'b1; // RL2
            state_d = (rem_after == 8'h00) ? mdt_pkg::PS_TTYPE : mdt_pkg::PS_TSKIP;
          end else if (i_tlv_byte == 8'h00) begin
            err    = exp_len != 8'h00; // RL12
            end_ok = rem_after == 8'h00;
            state_d = (rem_after == 8'h00) ? mdt_pkg::PS_TTYPE : mdt_pkg::PS_STYPE;
          end else begin
            sub_bad_d = exp_len != 8'h00 && exp_len != i_tlv_byte;
            err       = sub_bad_d; // RL12
            state_d   = mdt_pkg::PS_SVAL;
          end
        end
        mdt_pkg::PS_SVAL: begin
          acc_d     = val;
          sub_rem_d = sub_rem_q - 8'h01;
          top_rem_d = rem_after;
          if (sub_rem_q == 8'h01) begin
            commit  = !sub_bad_q && exp_len != 8'h00; // RL12
            end_ok  = top_rem_q == 8'h01;
            state_d = (top_rem_q == 8'h01) ? mdt_pkg::PS_TTYPE : mdt_pkg::PS_STYPE;
          end
        end
        default: begin
          state_d = mdt_pkg::PS_TTYPE;
        end
      endcase
    end
  end

  // value checks and update strobes
  always_comb begin
    upd_spacing = 1'b0;
    upd_verbose = 1'b0;
    upd_frag    = 1'b0;
    upd_prov    = 1'b0;
    upd_sid     = 1'b0;
    upd_sec     = 1'b0;
    seen_frag_d = seen_frag_q;
    seen_prov_d = seen_prov_q;
    if (state_q == mdt_pkg::PS_TLEN && state_d != mdt_pkg::PS_TLEN) begin
      seen_frag_d = 1'b0;
      seen_prov_d = 1'b0;
    end
    if (commit && is_prof) begin
      if (sub_type_q == mdt_pkg::SUB_SPACING) begin
        upd_spacing = val[7:0] <= mdt_pkg::MAX_BINARY; // RL3
      end else if (sub_type_q == mdt_pkg::SUB_VERBOSE) begin
        upd_verbose = val[7:0] <= mdt_pkg::MAX_BINARY; // RL4
      end else begin
        seen_frag_d = 1'b1;
        upd_frag    = val[7:0] == mdt_pkg::FRAG_PERMIT; // RL5
      end
    end
    if (commit && is_ip) begin
      if (sub_type_q == mdt_pkg::SUB_PROV) begin
        seen_prov_d = 1'b1;
        upd_prov    = val[7:0] <= mdt_pkg::MAX_PROV; // RL7
      end else begin
        upd_sid = val[23:20] == mdt_pkg::SID_RSVD_VAL; // RL8
      end
    end
    if (sec_take) begin
      upd_sec = i_tlv_byte <= mdt_pkg::MAX_BINARY; // RL11
    end
  end

  assign clr_frag = end_ok && is_prof && !seen_frag_d; // RL5

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q     <= mdt_pkg::PS_TTYPE;
      top_type_q  <= 8'h00;
      sub_type_q  <= 8'h00;
      top_rem_q   <= 8'h00;
      sub_rem_q   <= 8'h00;
      acc_q       <= 24'h000000;
      sub_bad_q   <= 1'b0;
      seen_frag_q <= 1'b0;
      seen_prov_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      top_type_q  <= top_type_d;
      sub_type_q  <= sub_type_d;
      top_rem_q   <= top_rem_d;
      sub_rem_q   <= sub_rem_d;
      acc_q       <= acc_d;
      sub_bad_q   <= sub_bad_d;
      seen_frag_q <= seen_frag_d;
      seen_prov_q <= seen_prov_d;
    end
  end

  // stored receive profile settings
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_spacing_8m  <= 1'b0;
      o_verbose     <= 1'b0;
      o_frag_permit <= 1'b0;
    end else begin
      if (upd_spacing) begin
        o_spacing_8m <= val[0]; // RL3
      end
      if (upd_verbose) begin
        o_verbose <= val[0]; // RL4
      end
      if (upd_frag) begin
        o_frag_permit <= 1'b1; // RL5
      end else if (clr_frag) begin
        o_frag_permit <= 1'b0; // RL5
      end
    end
  end

  // stored ip initialization and security settings
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prov_mode     <= mdt_pkg::PROV_RST;
      o_prereg_sid    <= mdt_pkg::SID_RST;
      o_early_auth_en <= 1'b0;
    end else begin
      if (upd_prov) begin
        o_prov_mode <= val[1:0]; // RL7
      end
      if (upd_sid) begin
        o_prereg_sid <= val[19:0]; // RL8
      end
      if (upd_sec) begin
        o_early_auth_en <= i_tlv_byte[0]; // RL11
      end
    end
  end

  // events and error flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ev_q        <= 4'h0;
      seen_q      <= 4'h0;
      o_parse_err <= 1'b0;
    end else begin
      o_parse_err <= err || (commit && !(upd_spacing || upd_verbose || upd_frag || upd_prov
                     || upd_sid)) || (sec_take && !upd_sec)
                     || (end_ok && is_ip && !seen_prov_d); // RL12 RL7
      ev_q[mdt_pkg::IRQ_PROF] <= end_ok && is_prof;
      ev_q[mdt_pkg::IRQ_IP]   <= end_ok && is_ip;
      ev_q[mdt_pkg::IRQ_SEC]  <= sec_take;
      ev_q[mdt_pkg::IRQ_ERR]  <= err || (commit && !(upd_spacing || upd_verbose || upd_frag
                                 || upd_prov || upd_sid)) || (sec_take && !upd_sec)
                                 || (end_ok && is_ip && !seen_prov_d);
      if (end_ok && is_prof) begin
        seen_q[0] <= 1'b1;
      end
      if (end_ok && is_ip) begin
        seen_q[1] <= 1'b1;
      end
      if (upd_sec) begin
        seen_q[2] <= 1'b1;
      end
      if (upd_sid) begin
        seen_q[3] <= 1'b1;
      end
    end
  end

  assign cfg.spacing_8m = o_spacing_8m;
  assign cfg.verbose    = o_verbose;
  assign cfg.frag       = o_frag_permit;
  assign cfg.prov       = o_prov_mode;
  assign cfg.sid        = o_prereg_sid;
  assign cfg.sec        = o_early_auth_en;
  assign cfg.seen       = seen_q;
  assign cfg.ev         = ev_q;

  mdt_wb_regs #(
    .ADDR_W (ADDR_W)
  ) u_regs (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_adr   (i_wb_adr),
    .i_dat   (i_wb_dat),
    .i_sel   (i_wb_sel),
    .i_we    (i_wb_we),
    .i_cyc   (i_wb_cyc),
    .i_stb   (i_wb_stb),
    .o_dat   (o_wb_dat),
    .o_ack   (o_wb_ack),
    .o_irq   (o_irq),
    .cfg     (cfg)
  );
endmodule

// *** tb/mdt_headend_model.sv ***
// headend model: sends descriptor elements one byte per clock
`timescale 1ns/1ps
module mdt_headend_model (
  input  wire logic       i_clk,
  output logic            o_start,
  output logic            o_valid,
  output logic [7:0]      o_byte
);
  initial begin
    o_start = 1'b0;
    o_valid = 1'b0;
    o_byte  = 8'h00;
  end
  // elements 4, 5 and 6 go out as on a primary-capable channel
  task automatic send(input logic [7:0] t, input logic [7:0] body[$],
                      input logic st);
    logic [7:0] all[$];
    all = {t, 8'(body.size()), body};
    foreach (all[i]) begin
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_start <= st && (i == 0);
      o_byte  <= all[i];
    end
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_start <= 1'b0;
    o_byte  <= ~all[all.size()-1];
  endtask
endmodule

// *** tb/mdt_decoder_asserts.sv ***
// checker: bus, parser and interrupt timing of the element decoder
`timescale 1ns/1ps
module mdt_decoder_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_tlv_start,
  input wire logic              i_tlv_valid,
  input wire logic [7:0]        i_tlv_byte,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [31:0]       i_wb_dat,
  input wire logic [3:0]        i_wb_sel,
  input wire logic              i_wb_we,
  input wire logic              i_wb_cyc,
  input wire logic              i_wb_stb,
  input wire logic [31:0]       o_wb_dat,
  input wire logic              o_wb_ack,
  input wire logic              o_irq,
  input wire logic              o_spacing_8m,
  input wire logic              o_verbose,
  input wire logic              o_frag_permit,
  input wire logic [1:0]        o_prov_mode,
  input wire logic [19:0]       o_prereg_sid,
  input wire logic              o_early_auth_en,
  input wire logic              o_parse_err
);
  logic       v;
  logic [7:0] b;
  assign v = i_tlv_valid;
  assign b = i_tlv_byte;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_sec;
    v && i_tlv_start && b == 8'h06 ##1 v && b == 8'h01;
  endsequence
  sequence s_sub4;
    v && i_tlv_start && b == 8'h04 ##1 v && b == 8'h03 ##1 v && b == 8'h01 ##1 v && b == 8'h01;
  endsequence
  sequence s_prov;
    v && i_tlv_start && b == 8'h05 ##1 v && b == 8'h03 ##1 v && b == 8'h01 ##1 v && b == 8'h01;
  endsequence
  sequence s_sid;
    v && i_tlv_start && b == 8'h05 ##1 v && b == 8'h08 ##1 v && b == 8'h01 ##1 v && b == 8'h01
      ##1 v && b <= 8'h03 ##1 v && b == 8'h02 ##1 v && b == 8'h03;
  endsequence
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_bus_answer: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
    else $error("bus request not answered next cycle");
  a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack cycle");
  a_hold_idle: assert property (!v |=>
      $stable({o_spacing_8m, o_verbose, o_frag_permit, o_prov_mode, o_prereg_sid,
      o_early_auth_en}))
    else $error("setting changed without a byte");
  a_sec_value: assert property (s_sec ##1 v && b <= 8'h01
      |=> o_early_auth_en == $past(b[0]))
    else $error("security enable not applied");
  a_sec_reserved: assert property (s_sec ##1 v && b > 8'h01
      |=> o_parse_err && $stable(o_early_auth_en))
    else $error("reserved security value accepted");
  a_spacing_value: assert property (s_sub4 ##1 v && b <= 8'h01
      |=> o_spacing_8m == $past(b[0]) && !o_frag_permit)
    else $error("spacing or fragment setting wrong");
  a_prov_value: assert property (s_prov ##1 v && b <= 8'h03
      |=> o_prov_mode == $past(b[1:0]))
    else $error("provisioning mode not applied");
  a_sid_value: assert property (s_sid ##1 v && b[7:4] == 4'h0 ##1 v ##1 v
      |=> o_prereg_sid == {$past(b[3:0], 3), $past(b, 2), $past(b)})
    else $error("stream id not applied");
  a_sid_reserved: assert property (s_sid ##1 v && b[7:4] != 4'h0 |=> ##[0:2] o_parse_err)
    else $error("reserved stream id bits not flagged");
  a_irq_fall: assert property ($fell(o_irq) |-> $past(i_wb_cyc && i_wb_stb && i_wb_we)
      || $past(i_wb_cyc && i_wb_stb && i_wb_we, 2) || $past(i_wb_cyc && i_wb_stb && i_wb_we, 3))
    else $error("interrupt dropped without a write");
endmodule

// *** tb/tb.sv ***
// testbench: headend element traffic and register accesses against the decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module tb;
  logic        i_clk;
  logic        i_rst_n;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [3:0]  sel;
  logic        we, cyc, stb, ack, irq, sp8, verb, frag, sec, perr, tstart, tvalid;
  logic [31:0] rdat, rd;
  logic [1:0]  prov;
  logic [19:0] sid;
  logic [7:0]  tbyte;
  int          n_fail = 0;
  int          compares = 0;
  int          n_err = 0;
  int          e0;
  mdt_headend_model i_head (.i_clk(i_clk), .o_start(tstart), .o_valid(tvalid), .o_byte(tbyte));
  mdt_decoder #(.ADDR_W(8)) i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tlv_start(tstart), .i_tlv_valid(tvalid),
    .i_tlv_byte(tbyte), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .i_wb_we(we),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq),
    .o_spacing_8m(sp8), .o_verbose(verb), .o_frag_permit(frag), .o_prov_mode(prov),
    .o_prereg_sid(sid), .o_early_auth_en(sec), .o_parse_err(perr));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (perr === 1'b1) n_err <= n_err + 1;
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    `CHK("ack", 1'b1, ack)
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic el(input logic [7:0] t, input logic [7:0] body[$]);
    i_head.send(t, body, 1'b1);
    repeat (3) @(posedge i_clk);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge i_clk);
    `CHK("irq", e, irq)
  endtask
  initial begin
    logic [7:0]  ofs [5];
    logic [31:0] rexp [5];
    ofs = '{mdt_pkg::OFS_CTRL, mdt_pkg::OFS_STATUS, mdt_pkg::OFS_SID, mdt_pkg::OFS_IRQ_STAT,
            mdt_pkg::OFS_IRQ_MASK};
    rexp = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
    i_rst_n = 1'b0;
    {cyc, stb, we, adr, wdat, sel} = '0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    `CHK("outputs", 28'h0, {sp8, verb, frag, prov, sid, sec, irq, perr})
    for (int k = 0; k < 5; k++) begin
      wb(ofs[k], 1'b0, 32'h0);
      `CHK("reset reg", rexp[k], rd)
    end
    el(8'h04, {8'h01, 8'h01, 8'h01});
    `CHK("profile", 3'b100, {sp8, verb, frag})
    e0 = n_err;
    el(8'h04, {8'h01, 8'h01, 8'h02});
    `CHK("spacing kept", 1'b1, sp8)
    `CHK("err", e0 + 1, n_err)
    el(8'h04, {8'h01, 8'h01, 8'h00, 8'h02, 8'h01, 8'h01, 8'h03, 8'h01, 8'h01});
    `CHK("profile full", 3'b011, {sp8, verb, frag})
    el(8'h04, {8'h03, 8'h01, 8'h00});
    `CHK("frag kept", 1'b1, frag)
    el(8'h04, {8'h09, 8'h02, 8'hAA, 8'hBB, 8'h02, 8'h01, 8'h00});
    `CHK("profile skip", 3'b000, {sp8, verb, frag})
    `CHK("err", e0 + 2, n_err)
    for (int p = 0; p < 4; p++) begin
      el(8'h05, {8'h01, 8'h01, 8'(p)});
      `CHK("prov", 2'(p), prov)
    end
    el(8'h05, {8'h01, 8'h01, 8'h04});
    `CHK("prov kept", 2'h3, prov)
    el(8'h05, {8'h01, 8'h01, 8'h03, 8'h02, 8'h03, 8'h0A, 8'hBC, 8'hDE});
    `CHK("sid", 20'hABCDE, sid)
    e0 = n_err;
    el(8'h05, {8'h01, 8'h01, 8'h03, 8'h02, 8'h03, 8'h1F, 8'hFF, 8'hFF});
    `CHK("sid kept", 20'hABCDE, sid)
    `CHK("err", e0 + 1, n_err)
    for (int k = 0; k < 2; k++) begin
      el(8'h06, {8'(k)});
      `CHK("sec", 1'(k), sec)
    end
    el(8'h06, {8'h02});
    el(8'h06, {8'h00, 8'h00});
    el(8'h09, {8'h06, 8'h01, 8'h00});
    el(8'h04, {8'h01, 8'h05, 8'h01});
    `CHK("sec kept", 1'b1, sec)
    `CHK("err", e0 + 4, n_err)
    wb(mdt_pkg::OFS_IRQ_STAT, 1'b1, 32'hF);
    wb(mdt_pkg::OFS_IRQ_MASK, 1'b1, 32'h1 << mdt_pkg::IRQ_ERR);
    irq_is(1'b0);
    el(8'h06, {8'h07});
    `CHK("irq", 1'b1, irq)
    wb(mdt_pkg::OFS_IRQ_STAT, 1'b0, 32'h0);
    `CHK("irq stat", (32'h1 << mdt_pkg::IRQ_ERR) | (32'h1 << mdt_pkg::IRQ_SEC), rd)
    wb(mdt_pkg::OFS_IRQ_MASK, 1'b1, 32'h0);
    irq_is(1'b0);
    wb(mdt_pkg::OFS_IRQ_MASK, 1'b1, 32'h1 << mdt_pkg::IRQ_ERR);
    irq_is(1'b1);
    wb(mdt_pkg::OFS_IRQ_STAT, 1'b1, 32'h1 << mdt_pkg::IRQ_ERR);
    irq_is(1'b0);
    wb(8'h40, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wb(mdt_pkg::OFS_SID, 1'b1, 32'hFFFFFFFF);
    wb(mdt_pkg::OFS_SID, 1'b0, 32'h0);
    `CHK("sid reg", 32'hABCDE, rd)
    wb(mdt_pkg::OFS_STATUS, 1'b0, 32'h0);
    rexp[1] = (32'h3 << mdt_pkg::ST_PROV) | (32'h1 << mdt_pkg::ST_SECURE);
    `CHK("status", rexp[1] | (32'hF << mdt_pkg::ST_PROF_SEEN), rd)
    wb(mdt_pkg::OFS_CTRL, 1'b1, 32'h0);
    i_head.send(8'h06, {8'h00}, 1'b0);
    repeat (3) @(posedge i_clk);
    `CHK("disabled", 1'b1, sec)
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    end_of_test();
  end
endmodule
bind mdt_decoder mdt_decoder_asserts #(.ADDR_W(ADDR_W)) i_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tlv_start(i_tlv_start), .i_tlv_valid(i_tlv_valid),
  .i_tlv_byte(i_tlv_byte), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
  .i_wb_we(i_wb_we), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_irq(o_irq), .o_spacing_8m(o_spacing_8m), .o_verbose(o_verbose),
  .o_frag_permit(o_frag_permit), .o_prov_mode(o_prov_mode), .o_prereg_sid(o_prereg_sid),
  .o_early_auth_en(o_early_auth_en), .o_parse_err(o_parse_err));
